// [core/irq_pkg.sv]
// package: constants for the interrupt request and acknowledge block
// assumes a 200 MHz core clock and a 12-bit apb byte address
package irq_pkg;
  localparam int NSRC = 8;
  localparam int NPER = 6;
  localparam int NEXT = 2;
  localparam int NPIN = 4;
  localparam int LVLW = 3;
  localparam int IDW  = 3;
  localparam int AW   = 12;
  localparam int DW   = 32;
  localparam int NEV  = 3;
  // register byte offsets
  localparam logic [AW-1:0] OFS_ACK    = 12'h000;
  localparam logic [AW-1:0] OFS_CTRL0  = 12'h004;
  localparam logic [AW-1:0] OFS_CTRLN  = 12'h020;
  localparam logic [AW-1:0] OFS_SRCSEL = 12'h024;
  localparam logic [AW-1:0] OFS_SP     = 12'h028;
  localparam logic [AW-1:0] OFS_MODE   = 12'h02C;
  localparam logic [AW-1:0] OFS_PORT8  = 12'h030;
  localparam logic [AW-1:0] OFS_ST     = 12'h034;
  localparam logic [AW-1:0] OFS_EN     = 12'h038;
  localparam logic [AW-1:0] OFS_CLR    = 12'h03C;
  // field positions
  localparam int CTL_LVL_LSB  = 0;
  localparam int CTL_FLAG_BIT = 3;
  localparam int CTL_POL_BIT  = 4;
  localparam int ACK_LVL_LSB  = 8;
  localparam int ACK_VLD_BIT  = 31;
  localparam int SP_ISP_LSB   = 16;
  localparam int MODE_GIE_BIT = 0;
  localparam int MODE_STOP_BIT = 1;
  localparam int P8_NMI_BIT   = 5;
  localparam int EV_NMI       = 0;
  localparam int EV_ACK_EMPTY = 1;
  localparam int EV_WAKE      = 2;
  // reset values
  localparam logic [15:0] SP_RESET = 16'h0000;
  // nmi pulse width seen from outside: 2 clocks plus 300 ns
  localparam int CLK_NS      = 5;
  localparam int NMI_MIN_NS  = 300;
  localparam int NMI_MIN_CYC = 2 + (NMI_MIN_NS + CLK_NS - 1) / CLK_NS;
  typedef enum logic [1:0] {
    ST_BOOT = 2'b00,
    ST_RUN  = 2'b01,
    ST_WAIT = 2'b11
  } core_state_t;
endpackage

// [core/pin_sync3.sv]
// module: three-flop synchroniser with agreement filter
// assumes asynchronous pin levels; output changes when stages 2 and 3 agree
`timescale 1ns/1ps
module pin_sync3 #(
  parameter int          W   = 1,
  parameter logic [W-1:0] RST = '1
) (
  // clock and reset
  input  wire logic         ref_clk_in,
  input  wire logic         rstn_in,
  // pins and filtered level
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] level_out
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] lvl_q;

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      s1_q <= RST;
      s2_q <= RST;
      s3_q <= RST;
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // one glitchy sample never reaches the level
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      lvl_q <= RST;
    end else begin
      lvl_q <= (s2_q & s3_q) | (lvl_q & (s2_q | s3_q));
    end
  end

  assign level_out = lvl_q;
endmodule // pin_sync3

// [core/irq_prio.sv]
// module: picks the pending source with the highest level
// assumes level 0 means disabled; ties go to the lower source number
`timescale 1ns/1ps
module irq_prio (
  // pending flags and levels
  input  wire logic [irq_pkg::NSRC-1:0]               flag_in,
  input  wire logic [irq_pkg::NSRC*irq_pkg::LVLW-1:0] lvl_in,
  // winner
  output logic                                        found_out,
  output logic [irq_pkg::IDW-1:0]                     idx_out,
  output logic [irq_pkg::LVLW-1:0]                    lvl_out
);
  always_comb begin
    found_out = 1'b0;
    idx_out   = '0;
    lvl_out   = '0;
    for (int i = irq_pkg::NSRC - 1; i >= 0; i--) begin
      if (flag_in[i] && lvl_in[i*irq_pkg::LVLW +: irq_pkg::LVLW] != '0 &&
          lvl_in[i*irq_pkg::LVLW +: irq_pkg::LVLW] >= lvl_out) begin
        found_out = 1'b1;
        idx_out   = irq_pkg::IDW'(i);
        lvl_out   = lvl_in[i*irq_pkg::LVLW +: irq_pkg::LVLW];
      end
    end
  end
endmodule // irq_prio

// [core/irq_ctrl.sv]
// module: interrupt request flags, acknowledge read, nmi, stack pointers
// assumes an apb master on ref_clk_in and a core that pulses on retire
`timescale 1ns/1ps
module irq_ctrl (
  // clock and reset
  input  wire logic                     ref_clk_in,
  input  wire logic                     rstn_in,
  // apb slave
  input  wire logic                     psel_in,
  input  wire logic                     penable_in,
  input  wire logic                     pwrite_in,
  input  wire logic [irq_pkg::AW-1:0]   paddr_in,
  input  wire logic [irq_pkg::DW-1:0]   pwdata_in,
  output logic      [irq_pkg::DW-1:0]   prdata_out,
  output logic                          pready_out,
  output logic                          pslverr_out,
  // request sources
  input  wire logic [irq_pkg::NPER-1:0] periph_req_in,
  input  wire logic [irq_pkg::NPIN-1:0] ext_irq_pin_in,
  input  wire logic                     nmi_n_in,
  // cpu core
  input  wire logic [irq_pkg::LVLW-1:0] cpu_ipl_in,
  input  wire logic                     instr_retire_in,
  input  wire logic                     wait_cmd_in,
  input  wire logic                     nmi_ack_in,
  output logic                          irq_req_out,
  output logic                          nmi_req_out,
  output logic                          halt_out,
  output logic                          cpu_clk_stop_out,
  output logic                          stop_mode_out,
  output logic [15:0]                   user_stack_ptr_out,
  output logic [15:0]                   irq_stack_ptr_out,
  // block interrupt
  input  wire logic                     int_out_unused_in,
  output logic                          irq_out
);
  localparam int N = irq_pkg::NSRC;
  localparam int L = irq_pkg::LVLW;
  localparam int CTL_LVL_LSB_W = irq_pkg::CTL_LVL_LSB;

  logic [irq_pkg::NPIN:0]    pin_lvl;
  logic                      nmi_lvl;
  logic                      nmi_prev_q;
  logic                      nmi_fall;
  logic                      nmi_pend_q;
  logic [N-1:0]              flag_q;
  logic [N-1:0]              src_evt;
  logic [N-1:0]              clr;
  logic [N*L-1:0]            lvl_q;
  logic [irq_pkg::NEXT-1:0]  pol_q;
  logic [7:0]                srcsel_q;
  logic [irq_pkg::NEXT-1:0]  ext_lvl;
  logic [irq_pkg::NEXT-1:0]  ext_prev_q;
  logic                      win_found;
  logic [irq_pkg::IDW-1:0]   win_idx;
  logic [L-1:0]              win_lvl;
  logic                      ack_vld_q;
  logic [irq_pkg::IDW-1:0]   ack_idx_q;
  logic [15:0]               usp_q;
  logic [15:0]               isp_q;
  logic                      gie_q;
  logic                      stop_q;
  irq_pkg::core_state_t      state_q;
  logic [irq_pkg::NEV-1:0]   st_q;
  logic [irq_pkg::NEV-1:0]   en_q;
  logic [irq_pkg::NEV-1:0]   ev;
  logic [irq_pkg::DW-1:0]    rd_d;
  logic [irq_pkg::DW-1:0]    prdata_q;
  logic                      setup;
  logic                      acc;
  logic                      wr;
  logic                      rd;
  logic                      in_ctrl;
  logic [irq_pkg::AW-1:0]    ctrl_ofs;
  logic [irq_pkg::IDW-1:0]   ctrl_idx;
  logic                      mapped;
  logic                      ack_fire;
  logic                      boot;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and priority

  pin_sync3 #(.W(irq_pkg::NPIN + 1)) u_sync (
    .ref_clk_in (ref_clk_in),
    .rstn_in    (rstn_in),
    .pin_in     ({nmi_n_in, ext_irq_pin_in}),
    .level_out  (pin_lvl)
  );
  assign nmi_lvl = pin_lvl[irq_pkg::NPIN];

  irq_prio u_prio (
    .flag_in   (flag_q),
    .lvl_in    (lvl_q),
    .found_out (win_found),
    .idx_out   (win_idx),
    .lvl_out   (win_lvl)
  );

  ////////////////////////////////////////////////////////////////////////////
  // apb decode

  assign setup    = psel_in && !penable_in;
  assign acc      = psel_in && penable_in;
  assign wr       = acc && pwrite_in && mapped;
  assign rd       = acc && !pwrite_in;
  assign ctrl_ofs = paddr_in - irq_pkg::OFS_CTRL0;
  assign ctrl_idx = ctrl_ofs[2 +: irq_pkg::IDW];
  assign in_ctrl  = paddr_in >= irq_pkg::OFS_CTRL0 &&
                    paddr_in <= irq_pkg::OFS_CTRLN && paddr_in[1:0] == 2'b00;
  assign mapped   = in_ctrl || paddr_in == irq_pkg::OFS_ACK ||
                    paddr_in == irq_pkg::OFS_SRCSEL ||
                    paddr_in == irq_pkg::OFS_SP ||
                    paddr_in == irq_pkg::OFS_MODE ||
                    paddr_in == irq_pkg::OFS_PORT8 ||
                    paddr_in == irq_pkg::OFS_ST ||
                    paddr_in == irq_pkg::OFS_EN ||
                    paddr_in == irq_pkg::OFS_CLR;
  // no wait states: read data is captured in the setup cycle
  assign pready_out  = acc;
  assign pslverr_out = acc && !mapped;
  assign prdata_out  = prdata_q;
  // core sequence and program read look identical here
  assign ack_fire = rd && paddr_in == irq_pkg::OFS_ACK && ack_vld_q;

  always_comb begin
    rd_d = '0;
    if (in_ctrl) begin
      rd_d[CTL_LVL_LSB_W +: L] = lvl_q[ctrl_idx*L +: L];
      rd_d[irq_pkg::CTL_FLAG_BIT] = flag_q[ctrl_idx];
      if (ctrl_idx >= irq_pkg::IDW'(irq_pkg::NPER)) begin
        rd_d[irq_pkg::CTL_POL_BIT] = pol_q[ctrl_idx[0]];
      end
    end else begin
      unique case (paddr_in)
        irq_pkg::OFS_ACK: begin
          rd_d[irq_pkg::IDW-1:0] = win_idx;
          rd_d[irq_pkg::ACK_LVL_LSB +: L] = win_lvl;
          rd_d[irq_pkg::ACK_VLD_BIT] = win_found;
        end
        irq_pkg::OFS_SRCSEL: rd_d[7:0] = srcsel_q;
        irq_pkg::OFS_SP: rd_d = {isp_q, usp_q};
        irq_pkg::OFS_MODE: begin
          rd_d[irq_pkg::MODE_GIE_BIT]  = gie_q;
          rd_d[irq_pkg::MODE_STOP_BIT] = stop_q;
        end
        irq_pkg::OFS_PORT8: rd_d[irq_pkg::P8_NMI_BIT] = nmi_lvl;
        irq_pkg::OFS_ST: rd_d[irq_pkg::NEV-1:0] = st_q;
        irq_pkg::OFS_EN: rd_d[irq_pkg::NEV-1:0] = en_q;
        default: rd_d = '0;
      endcase
    end
  end

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      prdata_q  <= '0;
      ack_vld_q <= 1'b0;
      ack_idx_q <= '0;
    end else if (setup) begin
      prdata_q  <= rd_d;
      ack_vld_q <= win_found;
      ack_idx_q <= win_idx;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      lvl_q    <= '0;
      pol_q    <= '0;
      srcsel_q <= '0;
    end else if (wr && in_ctrl) begin
      lvl_q[ctrl_idx*L +: L] <= pwdata_in[CTL_LVL_LSB_W +: L];
      if (ctrl_idx >= irq_pkg::IDW'(irq_pkg::NPER)) begin
        pol_q[ctrl_idx[0]] <= pwdata_in[irq_pkg::CTL_POL_BIT];
      end
    end else if (wr && paddr_in == irq_pkg::OFS_SRCSEL) begin
      srcsel_q <= pwdata_in[7:0];
    end
  end

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      usp_q <= irq_pkg::SP_RESET;
      isp_q <= irq_pkg::SP_RESET;
    end else if (wr && paddr_in == irq_pkg::OFS_SP) begin
      usp_q <= pwdata_in[15:0];
      isp_q <= pwdata_in[irq_pkg::SP_ISP_LSB +: 16];
    end
  end
  assign user_stack_ptr_out = usp_q;
  assign irq_stack_ptr_out  = isp_q;

  ////////////////////////////////////////////////////////////////////////////
  // pending request flags

  // normalised level: pol 0 means falling edge requests; any change of
  // select or polarity can look like an edge, which is the known hazard
  genvar g;
  generate
    for (g = 0; g < irq_pkg::NEXT; g++) begin : g_ext
      assign ext_lvl[g] = (srcsel_q[g] ? pin_lvl[2*g+1] : pin_lvl[2*g])
                          ^ ~pol_q[g];
    end
    for (g = 0; g < N; g++) begin : g_src
      if (g < irq_pkg::NPER) begin : g_per
        assign src_evt[g] = periph_req_in[g];
      end else begin : g_pin
        assign src_evt[g] = ext_lvl[g-irq_pkg::NPER] &
                            ~ext_prev_q[g-irq_pkg::NPER];
      end
      assign clr[g] = (ack_fire && ack_idx_q == irq_pkg::IDW'(g)) ||
                      (wr && in_ctrl && ctrl_idx == irq_pkg::IDW'(g) &&
                       !pwdata_in[irq_pkg::CTL_FLAG_BIT]);
      always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
          flag_q[g] <= 1'b0;
        end else begin
          // set beats a same-cycle clear or rewrite
          flag_q[g] <= src_evt[g] | (flag_q[g] & ~clr[g]);
        end
      end
    end
  endgenerate

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ext_prev_q <= '0;
    end else begin
      ext_prev_q <= ext_lvl;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // nmi, mode and core state

  assign nmi_fall = nmi_prev_q && !nmi_lvl;

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      nmi_prev_q <= 1'b1;
      nmi_pend_q <= 1'b0;
    end else begin
      nmi_prev_q <= nmi_lvl;
      nmi_pend_q <= nmi_fall | (nmi_pend_q & ~nmi_ack_in);
    end
  end

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      gie_q  <= 1'b0;
      stop_q <= 1'b0;
    end else begin
      if (wr && paddr_in == irq_pkg::OFS_MODE) begin
        gie_q  <= pwdata_in[irq_pkg::MODE_GIE_BIT];
        stop_q <= pwdata_in[irq_pkg::MODE_STOP_BIT] && nmi_lvl;
      end else if (!nmi_lvl || irq_req_out || nmi_req_out) begin
        stop_q <= 1'b0;
      end
    end
  end
  assign stop_mode_out = stop_q;

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_q <= irq_pkg::ST_BOOT;
    end else begin
      unique case (state_q)
        irq_pkg::ST_BOOT: if (instr_retire_in) state_q <= irq_pkg::ST_RUN;
        irq_pkg::ST_RUN:  if (wait_cmd_in) state_q <= irq_pkg::ST_WAIT;
        irq_pkg::ST_WAIT: begin
          if (irq_req_out || nmi_req_out) state_q <= irq_pkg::ST_RUN;
        end
        default: state_q <= irq_pkg::ST_BOOT;
      endcase
    end
  end

  assign boot        = state_q == irq_pkg::ST_BOOT;
  assign irq_req_out = !boot && gie_q && win_found &&
                       win_lvl > cpu_ipl_in;
  assign nmi_req_out = !boot && nmi_pend_q;
  assign halt_out    = state_q == irq_pkg::ST_WAIT;
  // nmi low in wait: execution stops but the clock keeps running
  assign cpu_clk_stop_out = halt_out && nmi_lvl;

  ////////////////////////////////////////////////////////////////////////////
  // block interrupt status

  assign ev[irq_pkg::EV_NMI]       = nmi_fall;
  assign ev[irq_pkg::EV_ACK_EMPTY] = rd && paddr_in == irq_pkg::OFS_ACK &&
                                     !ack_vld_q;
  assign ev[irq_pkg::EV_WAKE]      = halt_out &&
                                     (irq_req_out || nmi_req_out);

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st_q <= '0;
      en_q <= '0;
    end else begin
      if (wr && paddr_in == irq_pkg::OFS_CLR) begin
        st_q <= ev | (st_q & ~pwdata_in[irq_pkg::NEV-1:0]);
      end else begin
        st_q <= ev | st_q;
      end
      if (wr && paddr_in == irq_pkg::OFS_EN) begin
        en_q <= pwdata_in[irq_pkg::NEV-1:0];
      end
    end
  end
  assign irq_out = |(st_q & en_q);

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rstn_in);

  property p_ack_clear;
    (ack_fire && !src_evt[ack_idx_q]) |=> !flag_q[$past(ack_idx_q)];
  endproperty
  a_ack_clear: assert property (p_ack_clear) else $error("ack left flag");

  property p_ack_data;
    (setup && !pwrite_in && paddr_in == irq_pkg::OFS_ACK && win_found)
      |=> prdata_q[irq_pkg::IDW-1:0] == $past(win_idx) &&
          prdata_q[irq_pkg::ACK_VLD_BIT];
  endproperty
  a_ack_data: assert property (p_ack_data) else $error("ack data wrong");

  property p_sp_hold;
    !(wr && paddr_in == irq_pkg::OFS_SP) |=> $stable(usp_q) && $stable(isp_q);
  endproperty
  a_sp_hold: assert property (p_sp_hold) else $error("sp changed");

  property p_boot_block;
    boot |-> !irq_req_out && !nmi_req_out;
  endproperty
  a_boot_block: assert property (p_boot_block) else $error("early irq");

  property p_nmi_req;
    nmi_fall |=> nmi_pend_q && (boot || nmi_req_out);
  endproperty
  a_nmi_req: assert property (p_nmi_req) else $error("nmi lost");

  property p_p8;
    (setup && paddr_in == irq_pkg::OFS_PORT8)
      |=> prdata_q[irq_pkg::P8_NMI_BIT] == $past(nmi_lvl);
  endproperty
  a_p8: assert property (p_p8) else $error("port8 bit5 wrong");

  property p_stop_low;
    !nmi_lvl |=> !stop_q;
  endproperty
  a_stop_low: assert property (p_stop_low) else $error("stop with nmi");

  property p_wait_clk;
    (halt_out && !nmi_lvl) |-> !cpu_clk_stop_out;
  endproperty
  a_wait_clk: assert property (p_wait_clk) else $error("clock stopped");

  property p_set_win;
    src_evt[N-1] |=> flag_q[N-1];
  endproperty
  a_set_win: assert property (p_set_win) else $error("event lost");

  property p_hold;
    (flag_q[0] && !clr[0]) |=> flag_q[0];
  endproperty
  a_hold: assert property (p_hold) else $error("flag dropped");

  c_ack: cover property (ack_fire);
  c_nmi: cover property (nmi_fall ##[1:20] nmi_ack_in);
  c_wake: cover property (halt_out ##1 !halt_out);
endmodule // irq_ctrl

// [testbench/cpu_core_model.sv]
// cpu core stand-in: retires, sleeps and takes the nmi when told to
// assumes the controller's request outputs on the same clock
`timescale 1ns/1ps
module cpu_core_model (
  // clock and reset
  input  wire logic ref_clk_in,
  input  wire logic rstn_in,
  // from the controller
  input  wire logic nmi_req_in,
  input  wire logic halt_in,
  // bench commands
  input  wire logic step_in,
  input  wire logic sleep_in,
  input  wire logic take_in,
  input  wire logic slow_in,
  // to the controller
  output logic      retire_out,
  output logic      wait_out,
  output logic      nmi_ack_out
);
  logic [2:0] dly_q;
  ////////////////////////////////////////////////////////////////////////
  // a halted core retires nothing
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      retire_out <= 1'b0;
      wait_out   <= 1'b0;
    end else begin
      retire_out <= step_in && !halt_in;
      wait_out   <= sleep_in;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // nmi taken after a short or a long delay, one-cycle pulse
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      dly_q       <= 3'h0;
      nmi_ack_out <= 1'b0;
    end else if (nmi_req_in && take_in && !nmi_ack_out) begin
      dly_q       <= dly_q + 3'h1;
      nmi_ack_out <= dly_q >= (slow_in ? 3'h4 : 3'h0);
    end else begin
      dly_q       <= 3'h0;
      nmi_ack_out <= 1'b0;
    end
  end
endmodule // cpu_core_model

// [testbench/tb_top.sv]
// bench: interrupt request block with a core stand-in
// assumes irq_pkg and the core model are compiled first
`timescale 1ns/1ps
`define CHK(nm, e, g) \
  begin \
    tests_run++; \
    if ((g) !== (e)) begin \
      bad_count++; \
      $display("MISMATCH %s exp %0h got %0h", nm, e, g); \
    end \
  end
module tb_top;
  logic        clk, rstn, psel, pen, pwr, pready, pslverr, perr, nmi_n;
  logic        irq_req, nmi_req, halt, clk_stop, stop_mode, irq;
  logic        retire, waitc, nmi_ack, step, sleep, take, slow;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdv, e;
  logic [5:0]  preq, m;
  logic [3:0]  ext;
  logic [2:0]  ipl;
  logic [15:0] user_stack_ptr, irq_stack_ptr;
  logic [2:0]  lvl_m [8];
  logic [7:0]  pend_m;
  int          bad_count, tests_run;
  int          cyc = 0;

  irq_ctrl dut_u (
    .ref_clk_in(clk), .rstn_in(rstn), .psel_in(psel), .penable_in(pen),
    .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .periph_req_in(preq), .ext_irq_pin_in(ext), .nmi_n_in(nmi_n),
    .cpu_ipl_in(ipl), .instr_retire_in(retire), .wait_cmd_in(waitc),
    .nmi_ack_in(nmi_ack), .irq_req_out(irq_req), .nmi_req_out(nmi_req),
    .halt_out(halt), .cpu_clk_stop_out(clk_stop),
    .stop_mode_out(stop_mode), .user_stack_ptr_out(user_stack_ptr),
    .irq_stack_ptr_out(irq_stack_ptr), .int_out_unused_in(1'b0), .irq_out(irq));

  cpu_core_model core_u (
    .ref_clk_in(clk), .rstn_in(rstn), .nmi_req_in(nmi_req),
    .halt_in(halt), .step_in(step), .sleep_in(sleep), .take_in(take),
    .slow_in(slow), .retire_out(retire), .wait_out(waitc),
    .nmi_ack_out(nmi_ack));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // generous ceiling, the run needs well under a thousand cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      conclude();
    end
  end

  task automatic ticks(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel   <= 1'b1;
    pwr    <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    // no fixed latency assumed; the cycle ceiling ends a hang
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rdv  = prdata;
    perr = pslverr;
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [11:0] a);
    apb(1'b0, a, 32'h0000_0000);
  endtask

  task automatic pulse(input logic [5:0] v);
    @(posedge clk);
    preq <= v;
    @(posedge clk);
    preq <= 6'h00;
  endtask

  // which: 0 pulses step, 1 pulses sleep
  task automatic one_shot(input bit which);
    @(posedge clk);
    if (which) sleep <= 1'b1;
    else step <= 1'b1;
    @(posedge clk);
    step  <= 1'b0;
    sleep <= 1'b0;
  endtask

  function automatic logic [11:0] ctl(input int i);
    return irq_pkg::OFS_CTRL0 + 12'(4 * i);
  endfunction

  // highest level wins, ties to the lower source, level 0 is off
  function automatic logic [31:0] exp_ack();
    logic [31:0] r;
    r = 32'h0000_0000;
    for (int i = 7; i >= 0; i--) begin
      if (pend_m[i] && lvl_m[i] != 3'h0 && lvl_m[i] >= r[10:8]) begin
        r = {1'b1, 20'h00000, lvl_m[i], 5'h00, 3'(i)};
      end
    end
    return r;
  endfunction
  ////////////////////////////////////////////////////////////////////////
  initial begin
    {psel, pen, pwr, step, sleep, take, slow, ipl, preq} = '0;
    {paddr, pwdata, pend_m} = '0;
    {ext, nmi_n, rstn} = 6'h3E;
    bad_count = 0;
    tests_run = 0;
    foreach (lvl_m[i]) lvl_m[i] = 3'h0;
    void'($urandom(32'hC730C5DE));
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    `CHK("usp", 16'h0000, user_stack_ptr)
    `CHK("isp", 16'h0000, irq_stack_ptr)
    rd(irq_pkg::OFS_SP);
    `CHK("sp reg", 32'h0000_0000, rdv)
    e = $urandom;
    wr(irq_pkg::OFS_SP, e);
    rd(irq_pkg::OFS_SP);
    `CHK("sp load", e, rdv)
    `CHK("isp load", e[31:16], irq_stack_ptr)
    $display("test reset done");
    // nothing may be taken before the first instruction retires
    lvl_m[0] = 3'h3;
    wr(ctl(0), 32'h0000_0003);
    wr(irq_pkg::OFS_MODE, 32'h0000_0001);
    ticks(4);
    pulse(6'h01);
    nmi_n <= 1'b0;
    ticks(irq_pkg::NMI_MIN_CYC);
    `CHK("boot irq", 1'b0, irq_req)
    `CHK("boot nmi", 1'b0, nmi_req)
    nmi_n <= 1'b1;
    ticks(irq_pkg::NMI_MIN_CYC);
    one_shot(1'b0);
    ticks(2);
    `CHK("irq after boot", 1'b1, irq_req)
    take <= 1'b1;
    ipl  <= 3'h3;
    ticks(10);
    take <= 1'b0;
    `CHK("ipl blocks", 1'b0, irq_req)
    ipl <= 3'h0;
    pend_m = 8'h01;
    rd(irq_pkg::OFS_ACK);
    `CHK("ack", exp_ack(), rdv)
    pend_m = 8'h00;
    rd(ctl(0));
    `CHK("flag cleared", 32'h0000_0003, rdv)
    $display("test boot done");
    // random levels and bursts, acknowledged by program reads
    for (int i = 0; i < 6; i++) begin
      lvl_m[i] = 3'($urandom_range(7));
      wr(ctl(i), {29'h0, lvl_m[i]});
    end
    ipl <= 3'h7;
    for (int k = 0; k < 8; k++) begin
      m = 6'($urandom);
      if (k == 0) m = 6'h3F;
      pulse(m);
      pend_m |= {2'b00, m};
      rd(irq_pkg::OFS_ACK);
      e = exp_ack();
      `CHK("prog ack", e, rdv)
      if (e[31]) pend_m[e[2:0]] = 1'b0;
    end
    // writing 1 to a flag keeps it, writing 0 clears it
    for (int i = 0; i < 6; i++) wr(ctl(i), {28'h0, 1'b1, lvl_m[i]});
    rd(irq_pkg::OFS_ACK);
    e = exp_ack();
    `CHK("flag kept", e, rdv)
    if (e[31]) pend_m[e[2:0]] = 1'b0;
    for (int i = 0; i < 6; i++) wr(ctl(i), {29'h0, lvl_m[i]});
    pend_m = 8'h00;
    rd(irq_pkg::OFS_ACK);
    `CHK("all cleared", 32'h0000_0000, rdv)
    $display("test ack done");
    // external pin: edge, polarity change, source select
    wr(ctl(6), 32'h0000_0002);
    ext <= 4'hE;
    ticks(8);
    rd(ctl(6));
    `CHK("pin0 fall", 32'h0000_000A, rdv)
    wr(ctl(6), 32'h0000_0012);
    wr(ctl(6), 32'h0000_0012);
    rd(ctl(6));
    `CHK("pol clear", 32'h0000_0012, rdv)
    wr(irq_pkg::OFS_SRCSEL, 32'h0000_0001);
    wr(ctl(6), 32'h0000_0012);
    ext <= 4'hF;
    ticks(8);
    rd(ctl(6));
    `CHK("deselected", 32'h0000_0012, rdv)
    ext <= 4'hD;
    ticks(8);
    ext <= 4'hF;
    ticks(8);
    rd(ctl(6));
    `CHK("pin1 rise", 32'h0000_001A, rdv)
    wr(ctl(6), 32'h0000_0000);
    $display("test pins done");
    // nmi with everything masked, then wait with the pin low
    wr(irq_pkg::OFS_MODE, 32'h0000_0000);
    nmi_n <= 1'b0;
    ticks(irq_pkg::NMI_MIN_CYC);
    `CHK("nmi req", 1'b1, nmi_req)
    rd(irq_pkg::OFS_PORT8);
    `CHK("pin low", 1'b0, rdv[5])
    wr(irq_pkg::OFS_MODE, 32'h0000_0002);
    rd(irq_pkg::OFS_MODE);
    `CHK("stop bit", 2'b00, rdv[1:0])
    `CHK("stop out", 1'b0, stop_mode)
    slow <= 1'b1;
    take <= 1'b1;
    ticks(10);
    `CHK("nmi taken", 1'b0, nmi_req)
    take <= 1'b0;
    lvl_m[0] = 3'h3;
    wr(ctl(0), 32'h0000_0003);
    wr(irq_pkg::OFS_MODE, 32'h0000_0001);
    ipl <= 3'h0;
    ticks(4);
    one_shot(1'b1);
    ticks(2);
    `CHK("halted", 1'b1, halt)
    `CHK("clock kept", 1'b0, clk_stop)
    pulse(6'h01);
    ticks(2);
    `CHK("woken", 1'b0, halt)
    pend_m = 8'h01;
    rd(irq_pkg::OFS_ACK);
    `CHK("wake ack", exp_ack(), rdv)
    pend_m = 8'h00;
    nmi_n <= 1'b1;
    ticks(irq_pkg::NMI_MIN_CYC);
    rd(irq_pkg::OFS_PORT8);
    `CHK("pin high", 1'b1, rdv[5])
    $display("test nmi done");
    // block interrupt: sticky status, enable, clear, bad address
    rd(irq_pkg::OFS_ST);
    `CHK("status", 32'h0000_0007, rdv)
    `CHK("masked", 1'b0, irq)
    wr(irq_pkg::OFS_EN, 32'h0000_0004);
    ticks(1);
    `CHK("irq on", 1'b1, irq)
    wr(irq_pkg::OFS_CLR, 32'h0000_0004);
    ticks(1);
    `CHK("irq off", 1'b0, irq)
    rd(irq_pkg::OFS_ST);
    `CHK("status left", 32'h0000_0003, rdv)
    rd(irq_pkg::OFS_CLR);
    `CHK("clr reads 0", 32'h0000_0000, rdv)
    rd(12'h0FC);
    `CHK("bad addr err", 1'b1, perr)
    `CHK("bad addr data", 32'h0000_0000, rdv)
    $display("test status done");
    conclude();
  end
endmodule // tb_top
